// ===== inc/tpo_pkg.sv
// shared constants and types for the timer prescaler option block
package tpo_pkg;

    localparam int unsigned TPO_ADDR_W = 12;
    localparam int unsigned TPO_DATA_W = 32;

    // register indices as mapped in the register file; byte address is four times the index
    localparam logic [TPO_ADDR_W-1:0] TPO_CFG_IDX_LO = 12'h081;
    localparam logic [TPO_ADDR_W-1:0] TPO_CFG_IDX_HI = 12'h181;
    localparam logic [TPO_ADDR_W-1:0] TPO_STAT_IDX = 12'h082;
    localparam logic [TPO_ADDR_W-1:0] TPO_CFG_ADDR_LO = 12'h204;
    localparam logic [TPO_ADDR_W-1:0] TPO_CFG_ADDR_HI = 12'h604;
    localparam logic [TPO_ADDR_W-1:0] TPO_STAT_ADDR = 12'h208;

    // field positions of the configuration register
    localparam int unsigned TPO_PULLUP_DIS_BIT = 7;
    localparam int unsigned TPO_IRQ_EDGE_BIT = 6;
    localparam int unsigned TPO_CLK_SRC_BIT = 5;
    localparam int unsigned TPO_SRC_EDGE_BIT = 4;
    localparam int unsigned TPO_PS_ASSIGN_BIT = 3;
    localparam int unsigned TPO_RATE_LSB = 0;
    localparam int unsigned TPO_RATE_W = 3;

    localparam logic [7:0] TPO_CFG_RESET = 8'hFF;
    localparam logic [7:0] TPO_PS_CNT_RESET = 8'h00;
    localparam int unsigned TPO_PS_CNT_W = 8;
    localparam int unsigned TPO_SHIFT_W = 4;

    typedef struct packed {
        logic pullup_disable_n;
        logic ext_irq_edge_sel;
        logic timer_clk_source_sel;
        logic timer_source_edge_sel;
        logic prescaler_assign;
        logic [TPO_RATE_W-1:0] prescale_rate;
    } tpo_cfg_t;

    typedef struct packed {
        logic timer_tick;
        logic watchdog_tick;
        logic ext_irq_event;
    } tpo_evt_t;

endpackage

// ===== rtl/tpo_edge_det.sv
// selectable rising or falling edge detector with registered pulse
`timescale 1ns/1ps
`default_nettype none
module tpo_edge_det (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic sig_in,
    input wire logic fall_sel,
    output logic pulse
);
    logic prev_ff;
    logic pulse_ff;
    logic primed_ff;
    logic nxt_prev;
    logic nxt_pulse;
    logic nxt_primed;

    always_comb begin
        nxt_prev = sig_in;
        nxt_primed = 1'b1;
        // no edge until the pin has been sampled once, whatever its idle level
        nxt_pulse = primed_ff & (fall_sel ? (prev_ff & ~sig_in) : (~prev_ff & sig_in));
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prev_ff <= 1'b0;
            pulse_ff <= 1'b0;
            primed_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            pulse_ff <= nxt_pulse;
            primed_ff <= nxt_primed;
        end
    end

    assign pulse = pulse_ff;
endmodule // tpo_edge_det
`default_nettype wire

// ===== rtl/tpo_prescaler.sv
// shared ripple-style prescaler: divides input pulses by 2^shift
`timescale 1ns/1ps
`default_nettype none
module tpo_prescaler
    import tpo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clr,
    input wire logic in_pulse,
    input wire logic [TPO_SHIFT_W-1:0] shift,
    output logic tick,
    output logic [TPO_PS_CNT_W-1:0] count
);
    logic [TPO_PS_CNT_W-1:0] cnt_ff;
    logic [TPO_PS_CNT_W-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;
    logic [TPO_PS_CNT_W:0] span;
    logic [TPO_PS_CNT_W-1:0] mask;

    always_comb begin
        span = (9'h001 << shift);
        mask = span[TPO_PS_CNT_W-1:0] - 8'h01;
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (clr) begin
            nxt_cnt = TPO_PS_CNT_RESET;
        end else if (in_pulse) begin
            nxt_cnt = cnt_ff + 8'h01;
            // full period reached when all low bits of the count are set
            nxt_tick = ((cnt_ff & mask) == mask);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= TPO_PS_CNT_RESET;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
    assign count = cnt_ff;
endmodule // tpo_prescaler
`default_nettype wire

// ===== rtl/tpo_top.sv
// option register with apb access, driving timer, watchdog, irq edge and pull-up logic
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - one 8-bit rw register, two aliases, resets all-ones
// - bit 7 high disables pull-ups, else latch-controlled
// - bit 6 picks external interrupt rising or falling
// - bit 5 picks external pin or instruction clock
// - bit 4 picks external clock pin edge
// - bit 3 gives prescaler to watchdog or timer
module tpo_top
    import tpo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TPO_ADDR_W-1:0] paddr,
    input wire logic [TPO_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [TPO_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] input_port_b_latch,
    output logic [7:0] input_port_b_pullup_en,
    input wire logic ext_irq_pin,
    output logic ext_irq_event,
    input wire logic ext_timer_clk_pin,
    input wire logic instr_cycle_clk,
    input wire logic watchdog_osc_tick,
    output logic eight_bit_timer_inc,
    output logic watchdog_unit_inc,
    output tpo_cfg_t cfg_out
);

    // configuration register and apb read data
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic [TPO_DATA_W-1:0] rdata_ff;
    logic [TPO_DATA_W-1:0] nxt_rdata;
    logic err_ff;
    logic nxt_err;
    tpo_cfg_t cfg;

    // decode
    logic setup_ph;
    logic access_ph;
    logic hit_cfg;
    logic hit_stat;
    logic mapped;

    // pull-up outputs
    logic [7:0] pullup_ff;
    logic [7:0] nxt_pullup;

    // timer path
    logic ext_clk_edge;
    logic timer_src_pulse;
    logic ps_in_pulse;
    logic ps_tick;
    logic ps_clr;
    logic [TPO_SHIFT_W-1:0] ps_shift;
    logic [TPO_PS_CNT_W-1:0] ps_count;
    logic assign_prev_ff;
    logic nxt_assign_prev;
    logic timer_inc_ff;
    logic nxt_timer_inc;
    logic wdt_inc_ff;
    logic nxt_wdt_inc;
    logic irq_pulse;
    logic [2:0] src_sync_ff;
    logic [2:0] nxt_src_sync;

    assign cfg = tpo_cfg_t'(cfg_ff);

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_cfg = (paddr == TPO_CFG_ADDR_LO) | (paddr == TPO_CFG_ADDR_HI);
    assign hit_stat = (paddr == TPO_STAT_ADDR);
    assign mapped = hit_cfg | (hit_stat & ~pwrite);

    // register file: write in the access phase, read data staged in setup
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        if (access_ph & pwrite & hit_cfg & pstrb[0]) begin
            nxt_cfg = pwdata[7:0];
        end
        if (setup_ph) begin
            nxt_err = ~mapped;
            nxt_rdata = '0;
            if (~pwrite & hit_cfg) begin
                nxt_rdata = {24'h000000, cfg_ff};
            end else if (~pwrite & hit_stat) begin
                nxt_rdata = {16'h0000, ps_count, 5'h00, src_sync_ff};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_ff <= TPO_CFG_RESET;
            rdata_ff <= '0;
            err_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    assign prdata = rdata_ff;
    assign pready = 1'b1;
    assign pslverr = access_ph & err_ff;

    // weak pull-up enables per port line
    for (genvar gi = 0; gi < 8; gi++) begin : g_pullup
        assign nxt_pullup[gi] = ~cfg.pullup_disable_n & input_port_b_latch[gi];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pullup_ff <= 8'h00;
        end else begin
            pullup_ff <= nxt_pullup;
        end
    end

    assign input_port_b_pullup_en = pullup_ff;

    // external interrupt edge: select one means rising, so falling is its inverse
    tpo_edge_det u_irq_edge (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sig_in(ext_irq_pin),
        .fall_sel(~cfg.ext_irq_edge_sel),
        .pulse(irq_pulse)
    );

    assign ext_irq_event = irq_pulse;

    // external timer clock edge: one means high-to-low
    tpo_edge_det u_tclk_edge (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sig_in(ext_timer_clk_pin),
        .fall_sel(cfg.timer_source_edge_sel),
        .pulse(ext_clk_edge)
    );

    // timer count source
    assign timer_src_pulse = cfg.timer_clk_source_sel ? ext_clk_edge : instr_cycle_clk;

    // prescaler input and division; rate zero on the watchdog passes every pulse
    always_comb begin
        if (cfg.prescaler_assign) begin
            ps_in_pulse = watchdog_osc_tick;
            ps_shift = {1'b0, cfg.prescale_rate};
        end else begin
            ps_in_pulse = timer_src_pulse;
            ps_shift = {1'b0, cfg.prescale_rate} + 4'h1;
        end
    end

    // reassigning the prescaler restarts it so no stale count leaks across
    always_comb begin
        nxt_assign_prev = cfg.prescaler_assign;
        ps_clr = (assign_prev_ff != cfg.prescaler_assign);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            assign_prev_ff <= 1'b1;
        end else begin
            assign_prev_ff <= nxt_assign_prev;
        end
    end

    tpo_prescaler u_ps (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clr(ps_clr),
        .in_pulse(ps_in_pulse),
        .shift(ps_shift),
        .tick(ps_tick),
        .count(ps_count)
    );

    // route increments: only the owner sees prescaled ticks
    always_comb begin
        if (cfg.prescaler_assign) begin
            nxt_timer_inc = timer_src_pulse;
            nxt_wdt_inc = ps_tick & ~ps_clr;
        end else begin
            nxt_timer_inc = ps_tick & ~ps_clr;
            nxt_wdt_inc = watchdog_osc_tick;
        end
        nxt_src_sync = {cfg.timer_clk_source_sel, ext_timer_clk_pin, ext_irq_pin};
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timer_inc_ff <= 1'b0;
            wdt_inc_ff <= 1'b0;
            src_sync_ff <= 3'h0;
        end else begin
            timer_inc_ff <= nxt_timer_inc;
            wdt_inc_ff <= nxt_wdt_inc;
            src_sync_ff <= nxt_src_sync;
        end
    end

    assign eight_bit_timer_inc = timer_inc_ff;
    assign watchdog_unit_inc = wdt_inc_ff;
    assign cfg_out = cfg;

endmodule // tpo_top
`default_nettype wire

// ===== dv/tpo_checker.sv
// concurrent checks on the option block ports
`timescale 1ns/1ps
`default_nettype none
module tpo_checker
    import tpo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TPO_ADDR_W-1:0] paddr,
    input wire logic [TPO_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [TPO_DATA_W-1:0] prdata,
    input wire logic pslverr,
    input wire logic [7:0] input_port_b_latch,
    input wire logic [7:0] input_port_b_pullup_en,
    input wire logic ext_irq_pin,
    input wire logic ext_irq_event,
    input wire logic ext_timer_clk_pin,
    input wire logic instr_cycle_clk,
    input wire logic watchdog_osc_tick,
    input wire logic eight_bit_timer_inc,
    input wire logic watchdog_unit_inc,
    input wire tpo_cfg_t cfg_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic hit;
    logic acc;
    assign hit = (paddr == TPO_CFG_ADDR_LO) || (paddr == TPO_CFG_ADDR_HI);
    assign acc = psel && penable;
    AST_RST_ONES: assert property ($rose(resetn) |-> cfg_out == 8'hFF)
        else $error("config not all ones after reset");
    AST_WR_ALIAS: assert property (acc && pwrite && pstrb[0] && hit
        |=> cfg_out == $past(pwdata[7:0])) else $error("config write lost");
    AST_RD_ALIAS: assert property (acc && !pwrite && hit
        |-> prdata == {24'h0, cfg_out} && !pslverr) else $error("config read wrong");
    AST_UNMAP: assert property (acc && !hit && paddr != TPO_STAT_ADDR
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    AST_PULLUP: assert property (1'b1 |=> input_port_b_pullup_en ==
        ($past(input_port_b_latch) & ~{8{$past(cfg_out.pullup_disable_n)}})) else $error("pull-up enables wrong");
    AST_IRQ_RISE: assert property ($past(resetn) && cfg_out.ext_irq_edge_sel && $rose(ext_irq_pin)
        |-> ##[1:2] ext_irq_event) else $error("rising irq edge missed");
    AST_IRQ_FALL: assert property ($past(resetn) && !cfg_out.ext_irq_edge_sel && $fell(ext_irq_pin)
        |-> ##[1:2] ext_irq_event) else $error("falling irq edge missed");
    AST_TMR_INT: assert property ($stable(cfg_out) && !cfg_out.timer_clk_source_sel
        && cfg_out.prescaler_assign && instr_cycle_clk |=> eight_bit_timer_inc) else $error("timer tick missed");
    AST_TMR_EXT: assert property ($past(resetn) && $stable(cfg_out) && cfg_out.timer_clk_source_sel
        && cfg_out.prescaler_assign
        && (cfg_out.timer_source_edge_sel ? $fell(ext_timer_clk_pin) : $rose(ext_timer_clk_pin))
        |-> ##[1:2] eight_bit_timer_inc) else $error("external timer edge missed");
    AST_WDT_PASS: assert property ($stable(cfg_out) && !cfg_out.prescaler_assign
        && watchdog_osc_tick |=> watchdog_unit_inc) else $error("watchdog tick missed");
    COV_WR: cover property (acc && pwrite && hit);
    COV_IRQ: cover property (ext_irq_event);
    COV_WDT: cover property (cfg_out.prescaler_assign && watchdog_unit_inc);
endmodule // tpo_checker
bind tpo_top tpo_checker chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .input_port_b_latch(input_port_b_latch), .input_port_b_pullup_en(input_port_b_pullup_en),
    .ext_irq_pin(ext_irq_pin), .ext_irq_event(ext_irq_event), .ext_timer_clk_pin(ext_timer_clk_pin),
    .instr_cycle_clk(instr_cycle_clk), .watchdog_osc_tick(watchdog_osc_tick),
    .eight_bit_timer_inc(eight_bit_timer_inc), .watchdog_unit_inc(watchdog_unit_inc), .cfg_out(cfg_out));
`default_nettype wire

// ===== dv/test_timer_prescaler_option_control.sv
// self-checking bench for the option block
`timescale 1ns/1ps
`default_nettype none
module test_timer_prescaler_option_control
    import tpo_pkg::*;
;
    logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0] pstrb = 4'hF;
    logic ext_irq_pin = 1'b0, ext_irq_event, ext_timer_clk_pin = 1'b0, instr_cycle_clk = 1'b0;
    logic watchdog_osc_tick = 1'b0, eight_bit_timer_inc, watchdog_unit_inc;
    logic [7:0] input_port_b_latch = 8'h00, input_port_b_pullup_en;
    tpo_cfg_t cfg_out;
    int error_cnt = 0, samples_checked = 0, tcnt = 0, wcnt = 0, ecnt = 0;
    tpo_top dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_port_b_latch(input_port_b_latch), .input_port_b_pullup_en(input_port_b_pullup_en),
        .ext_irq_pin(ext_irq_pin), .ext_irq_event(ext_irq_event), .ext_timer_clk_pin(ext_timer_clk_pin),
        .instr_cycle_clk(instr_cycle_clk), .watchdog_osc_tick(watchdog_osc_tick),
        .eight_bit_timer_inc(eight_bit_timer_inc), .watchdog_unit_inc(watchdog_unit_inc), .cfg_out(cfg_out));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (eight_bit_timer_inc === 1'b1) tcnt <= tcnt + 1;
        if (watchdog_unit_inc === 1'b1) wcnt <= wcnt + 1;
        if (ext_irq_event === 1'b1) ecnt <= ecnt + 1;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, v}, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        cmp(r, x);
        cmp({31'h0, e}, {31'h0, xe});
    endtask
    task automatic t_reg();
        cmp({24'h000000, cfg_out}, 32'h0000_00FF);
        // status: count 0, clock source bit 1, both pins low
        rd(TPO_STAT_ADDR, 32'h0000_0004, 1'b0);
        rd(TPO_CFG_ADDR_LO, 32'hFF, 1'b0);
        rd(TPO_CFG_ADDR_HI, 32'hFF, 1'b0);
        wr(TPO_CFG_ADDR_HI, 8'h5A);
        cmp({24'h000000, cfg_out}, 32'h0000_005A);
        rd(TPO_CFG_ADDR_LO, 32'h5A, 1'b0);
        wr(TPO_CFG_ADDR_LO, 8'hA5);
        rd(TPO_CFG_ADDR_HI, 32'hA5, 1'b0);
        rd(12'h100, 32'h0, 1'b1);
        $display("register test done");
    endtask
    task automatic t_pull();
        wr(TPO_CFG_ADDR_LO, 8'h7F);
        input_port_b_latch <= 8'hA5;
        repeat (3) @(posedge ref_clk);
        cmp({24'h0, input_port_b_pullup_en}, 32'hA5);
        wr(TPO_CFG_ADDR_LO, 8'hFF);
        repeat (2) @(posedge ref_clk);
        cmp({24'h0, input_port_b_pullup_en}, 32'h0);
        $display("pull-up test done");
    endtask
    // one rising then one falling pin edge; x is the count expected after the rise
    task automatic t_edge(input logic [7:0] c, input logic tm, input int x);
        int b;
        wr(TPO_CFG_ADDR_LO, c);
        // counters belong to the sampling process; only their growth is judged
        b = tm ? tcnt : ecnt;
        if (tm) ext_timer_clk_pin <= 1'b1;
        else ext_irq_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cmp(tm ? tcnt - b : ecnt - b, x);
        if (tm) ext_timer_clk_pin <= 1'b0;
        else ext_irq_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cmp(tm ? tcnt - b : ecnt - b, 1);
        $display("edge test done cfg %h", c);
    endtask
    // each write after the first flips the assignment bit, which clears the prescaler
    task automatic t_rate();
        int tb;
        int wb;
        for (int n = 0; n < 8; n++) begin
            for (int a = 1; a >= 0; a--) begin
                wr(TPO_CFG_ADDR_LO, 8'hD0 | 8'(a << 3) | 8'(n));
                tb = tcnt;
                wb = wcnt;
                instr_cycle_clk <= 1'b1;
                watchdog_osc_tick <= 1'b1;
                repeat (512) @(posedge ref_clk);
                instr_cycle_clk <= 1'b0;
                watchdog_osc_tick <= 1'b0;
                repeat (4) @(posedge ref_clk);
                cmp(tcnt - tb, a ? 512 : 512 >> (n + 1));
                cmp(wcnt - wb, a ? 512 >> n : 512);
            end
        end
        $display("rate test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reg();
        t_pull();
        t_edge(8'hC8, 1'b0, 1);
        t_edge(8'h88, 1'b0, 0);
        t_edge(8'hA8, 1'b1, 1);
        t_edge(8'hB8, 1'b1, 0);
        t_rate();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        close_out();
    end
endmodule // test_timer_prescaler_option_control
`default_nettype wire
